/* rtl/transmit_process_object_pkg.sv */
package transmit_process_object_pkg;
  localparam int N_OBJ = 4;
  localparam int MAP_MAX = 4;
  localparam int PAYLOAD_BITS = 64;
  localparam int FRAME_W = 79;
  localparam int FIFO_DEPTH = 4;
  localparam logic [15:0] IDX_SYNC = 16'h1015;
  localparam logic [15:0] IDX_COMM = 16'h1800;
  localparam logic [15:0] IDX_MAP = 16'h1A00;
  localparam logic [7:0] SUB_CNT = 8'h00;
  localparam logic [7:0] SUB_COB = 8'h01;
  localparam logic [7:0] SUB_TYPE = 8'h02;
  localparam logic [7:0] SUB_INH = 8'h03;
  localparam logic [7:0] SUB_RSV = 8'h04;
  localparam logic [7:0] SUB_EVT = 8'h05;
  localparam logic [31:0] COMM_LAST_SUB = 32'h00000005;
  localparam logic [31:0] SYNC_ID_RST = 32'h00000080;
  localparam logic [10:0] COB_BASE = 11'h180;
  localparam logic [10:0] COB_STEP = 11'h100;
  localparam int COB_DIS_BIT = 31;
  localparam logic [7:0] TYPE_RST = 8'hFE;
  localparam logic [15:0] EVT_RST = 16'h0000;
  localparam logic [15:0] EVT_MIN = 16'h0002;
  localparam logic [2:0] MAPCNT_RST = 3'h0;
  localparam logic [7:0] T_SYNC_ONCE = 8'h00;
  localparam logic [7:0] T_SYNC_MAX = 8'hF0;
  localparam logic [7:0] T_SYNC_RTR = 8'hFC;
  localparam logic [7:0] T_RTR = 8'hFD;
  localparam logic [7:0] T_EVENT = 8'hFE;
  localparam logic [7:0] T_COS = 8'hFF;
  localparam int CLK_NS = 10;
  localparam int GAP_UNIT_NS = 100000;
  localparam int MS_NS = 1000000;
  localparam int GAP_UNIT_CYC = GAP_UNIT_NS / CLK_NS;
  localparam logic [3:0] MS_DIV = 4'(MS_NS / GAP_UNIT_NS);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_FETCH = 3'b010,
    S_PUSH = 3'b100
  } sched_e;
endpackage : transmit_process_object_pkg

/* rtl/frame_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface frame_if;
  logic valid;
  logic ready;
  logic [transmit_process_object_pkg::FRAME_W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : frame_if
`default_nettype wire

/* rtl/frame_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module frame_fifo #(
  parameter int W = transmit_process_object_pkg::FRAME_W,
  parameter int DEPTH = transmit_process_object_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset
  frame_if.snk in_f, // Frames from the scheduler
  output logic out_valid, // Frame available
  input wire logic out_ready, // Consumer takes frame
  output logic [W-1:0] out_data // Head frame
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_s;
  fifo_s q;
  fifo_s n;
  logic push;
  logic pop;
  always_comb begin
    in_f.ready = q.cnt != (AW+1)'(DEPTH);
    out_valid = q.cnt != '0;
    out_data = q.mem[q.rp];
    push = in_f.valid && in_f.ready;
    pop = out_valid && out_ready;
    n = q;
    if (push) begin
      n.mem[q.wp] = in_f.data;
      n.wp = q.wp + 1'b1;
    end
    if (pop) begin
      n.rp = q.rp + 1'b1;
    end
    n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule : frame_fifo
`default_nettype wire

/* rtl/gap_tick.sv */
`timescale 1ns/1ns
`default_nettype none
module gap_tick #(
  parameter int unsigned CYC = transmit_process_object_pkg::GAP_UNIT_CYC
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset
  output logic tick // One pulse per 100 us unit
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tick_s;
  tick_s q;
  tick_s n;
  always_comb begin
    n = q;
    n.tick = q.cnt == 16'(CYC - 1);
    n.cnt = n.tick ? 16'h0000 : q.cnt + 16'h0001;
    tick = q.tick;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule : gap_tick
`default_nettype wire

/* rtl/canopen_transmit_process_object_sync_scheduler.sv */
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Four transmit objects, up to eight bytes
// - Default identifiers 180h..480h plus node number
// - Frame carries the object's configured identifier
// - Type 0 sends once after SYNC
// - Types 1-240 send every Nth SYNC
// - Type 252 latches on SYNC, sends on remote
// - Type 253 refreshes and sends on remote
// - Type 254 sends on event timer
// - Type 255 sends on change, plus timer
// - Inhibit gap in 100 us; zero disables
// - Event timer counts 1 ms units
// - Event timer never below 2 ms
// - Objects run only when operational
// - Entry is index, sub-index, bit length
// - At most four entries, eight bytes total
// - SYNC consumer, identifier default 80h
// - Bit 31 disables, bits 10:0 identifier
module canopen_transmit_process_object_sync_scheduler #(
  parameter int unsigned GAP_UNIT_CYCLES = transmit_process_object_pkg::GAP_UNIT_CYC
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset
  input wire logic [6:0] node_number, // Node address
  input wire logic operational, // Node in operational state
  input wire logic rx_valid, // Received frame strobe
  input wire logic [10:0] rx_id, // Received identifier
  input wire logic rx_rtr, // Received frame is remote
  input wire logic cfg_wr, // Dictionary write
  input wire logic cfg_rd, // Dictionary read
  input wire logic [15:0] cfg_index, // Dictionary index
  input wire logic [7:0] cfg_sub, // Dictionary sub-index
  input wire logic [31:0] cfg_wdata, // Write value
  output logic cfg_done, // Access answered
  output logic cfg_err, // Access refused
  output logic [31:0] cfg_rdata, // Read value
  output logic [15:0] dict_index, // Mapped object index
  output logic [7:0] dict_sub, // Mapped object sub-index
  input wire logic [31:0] dict_data, // Mapped object value
  output logic tx_valid, // Frame to send
  input wire logic tx_ready, // Controller takes frame
  output logic [10:0] tx_id, // Frame identifier
  output logic [3:0] tx_dlc, // Frame byte count
  output logic [63:0] tx_data // Frame payload, byte 0 low
);
  typedef struct packed {
    logic init;
    transmit_process_object_pkg::sched_e st;
    logic [1:0] obj;
    logic [1:0] ent;
    logic [6:0] pos;
    logic [63:0] pack;
    logic act_send;
    logic act_latch;
    logic act_cos;
    logic [15:0] dq_index;
    logic [7:0] dq_sub;
    logic [3:0] ms_div;
    logic [31:0] sync_id;
    logic [3:0][31:0] cob;
    logic [3:0][7:0] ttype;
    logic [3:0][15:0] inh;
    logic [3:0][15:0] evt;
    logic [3:0][2:0] mcnt;
    logic [3:0][3:0][31:0] map;
    logic [3:0][7:0] scnt;
    logic [3:0][16:0] inh_cnt;
    logic [3:0][15:0] evt_cnt;
    logic [3:0] p_send;
    logic [3:0] p_latch;
    logic [3:0] p_rtr;
    logic [3:0][63:0] data;
    logic [3:0][3:0] dlc;
    logic done;
    logic err;
    logic [31:0] rdata;
  } sched_s;

  function automatic logic [63:0] len_mask(input logic [7:0] len);
    len_mask = (len >= 8'd64) ? '1 : ((64'h1 << len) - 64'h1);
  endfunction : len_mask

  function automatic logic [10:0] map_bits(input logic [3:0][31:0] m, input logic [2:0] cnt);
    map_bits = '0;
    for (int i = 0; i < transmit_process_object_pkg::MAP_MAX; i++) begin
      if (3'(i) < cnt) begin
        map_bits = map_bits + {3'h0, m[i][7:0]};
      end
    end
  endfunction : map_bits

  sched_s q;
  sched_s n;
  logic tick_gap;
  logic ms_tick;
  logic sync_hit;
  logic fire;
  logic [3:0] live;
  logic [3:0] ok;
  logic [63:0] nb;
  logic [6:0] npos;
  logic [1:0] c;
  frame_if f_if();

  gap_tick #(.CYC(GAP_UNIT_CYCLES)) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick_gap)
  );

  frame_fifo #(.W(transmit_process_object_pkg::FRAME_W), .DEPTH(transmit_process_object_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_f(f_if.snk),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data({tx_id, tx_dlc, tx_data})
  );

  assign f_if.valid = q.st == transmit_process_object_pkg::S_PUSH;
  assign f_if.data = {q.cob[q.obj][10:0], q.dlc[q.obj], q.data[q.obj]};
  assign dict_index = q.dq_index;
  assign dict_sub = q.dq_sub;
  assign cfg_done = q.done;
  assign cfg_err = q.err;
  assign cfg_rdata = q.rdata;

  always_comb begin
    n = q;
    n.done = 1'b0;
    n.err = 1'b0;
    nb = '0;
    npos = '0;
    c = cfg_index[1:0];
    fire = 1'b0;
    if (!q.init) begin
      n.init = 1'b1;
      for (int o = 0; o < transmit_process_object_pkg::N_OBJ; o++) begin
        n.cob[o] = {21'h0, transmit_process_object_pkg::COB_BASE + 11'(o) * transmit_process_object_pkg::COB_STEP + {4'h0, node_number}};
      end
    end
    ms_tick = tick_gap && q.ms_div == transmit_process_object_pkg::MS_DIV - 4'h1;
    if (tick_gap) begin
      n.ms_div = ms_tick ? 4'h0 : q.ms_div + 4'h1;
    end
    sync_hit = rx_valid && !rx_rtr && rx_id == q.sync_id[10:0];
    for (int o = 0; o < transmit_process_object_pkg::N_OBJ; o++) begin
      live[o] = operational && !q.cob[o][transmit_process_object_pkg::COB_DIS_BIT] && q.mcnt[o] != 3'h0;
      ok[o] = q.inh_cnt[o] == 17'h00000;
    end

    // Scheduler: one object served at a time, round robin
    unique case (q.st)
      transmit_process_object_pkg::S_IDLE: begin
        if (live[q.obj] && q.p_rtr[q.obj] && ok[q.obj]) begin
          n.p_rtr[q.obj] = 1'b0;
          n.st = transmit_process_object_pkg::S_PUSH;
        end else if (live[q.obj] && ((q.p_send[q.obj] && ok[q.obj]) || q.p_latch[q.obj]
                     || (q.ttype[q.obj] == transmit_process_object_pkg::T_COS && ok[q.obj]))) begin
          n.act_send = q.p_send[q.obj] && ok[q.obj];
          n.act_latch = q.p_latch[q.obj];
          n.act_cos = q.ttype[q.obj] == transmit_process_object_pkg::T_COS && ok[q.obj];
          if (n.act_send) begin
            n.p_send[q.obj] = 1'b0;
          end
          n.p_latch[q.obj] = 1'b0;
          n.ent = 2'h0;
          n.pos = 7'h00;
          n.pack = '0;
          n.dq_index = q.map[q.obj][0][31:16];
          n.dq_sub = q.map[q.obj][0][15:8];
          n.st = transmit_process_object_pkg::S_FETCH;
        end else begin
          n.obj = q.obj + 2'h1;
        end
      end
      transmit_process_object_pkg::S_FETCH: begin
        nb = q.pack | ({32'h0, dict_data} & len_mask(q.map[q.obj][q.ent][7:0])) << q.pos;
        npos = q.pos + q.map[q.obj][q.ent][6:0];
        n.pack = nb;
        n.pos = npos;
        if ({1'b0, q.ent} == q.mcnt[q.obj] - 3'h1) begin
          if (q.act_latch || q.act_send || (q.act_cos && nb != q.data[q.obj])) begin
            n.data[q.obj] = nb;
            n.dlc[q.obj] = 4'((8'(npos) + 8'd7) >> 3);
          end
          if (q.act_send || (q.act_cos && nb != q.data[q.obj])) begin
            n.st = transmit_process_object_pkg::S_PUSH;
          end else begin
            n.st = transmit_process_object_pkg::S_IDLE;
            n.obj = q.obj + 2'h1;
          end
        end else begin
          n.ent = q.ent + 2'h1;
          n.dq_index = q.map[q.obj][q.ent + 2'h1][31:16];
          n.dq_sub = q.map[q.obj][q.ent + 2'h1][15:8];
        end
      end
      transmit_process_object_pkg::S_PUSH: begin
        if (f_if.ready) begin
          fire = 1'b1;
          n.st = transmit_process_object_pkg::S_IDLE;
          n.obj = q.obj + 2'h1;
        end
      end
      default: begin
        n.st = transmit_process_object_pkg::S_IDLE;
      end
    endcase

    // Triggers, applied after the scheduler so a new event wins over its clear
    for (int o = 0; o < transmit_process_object_pkg::N_OBJ; o++) begin
      if (!live[o]) begin
        n.p_send[o] = 1'b0;
        n.p_latch[o] = 1'b0;
        n.p_rtr[o] = 1'b0;
        n.scnt[o] = 8'h00;
        n.evt_cnt[o] = 16'h0000;
      end else begin
        if (sync_hit) begin
          if (q.ttype[o] == transmit_process_object_pkg::T_SYNC_ONCE) begin
            n.p_send[o] = 1'b1;
          end else if (q.ttype[o] <= transmit_process_object_pkg::T_SYNC_MAX) begin
            if (q.scnt[o] + 8'h01 >= q.ttype[o]) begin
              n.p_send[o] = 1'b1;
              n.scnt[o] = 8'h00;
            end else begin
              n.scnt[o] = q.scnt[o] + 8'h01;
            end
          end else if (q.ttype[o] == transmit_process_object_pkg::T_SYNC_RTR) begin
            n.p_latch[o] = 1'b1;
          end
        end
        if (rx_valid && rx_rtr && rx_id == q.cob[o][10:0]) begin
          if (q.ttype[o] == transmit_process_object_pkg::T_SYNC_RTR) begin
            n.p_rtr[o] = 1'b1;
          end else if (q.ttype[o] == transmit_process_object_pkg::T_RTR) begin
            n.p_send[o] = 1'b1;
          end
        end
        if (q.ttype[o] >= transmit_process_object_pkg::T_EVENT && q.evt[o] != 16'h0000 && ms_tick) begin
          if (q.evt_cnt[o] + 16'h0001 >= q.evt[o]) begin
            n.p_send[o] = 1'b1;
            n.evt_cnt[o] = 16'h0000;
          end else begin
            n.evt_cnt[o] = q.evt_cnt[o] + 16'h0001;
          end
        end
      end
      if (tick_gap && !ok[o]) begin
        n.inh_cnt[o] = q.inh_cnt[o] - 17'h00001;
      end
    end
    if (fire) begin
      // One extra unit: the free-running tick may fall just after the send
      n.inh_cnt[q.obj] = (q.inh[q.obj] == 16'h0000) ? 17'h00000 : {1'b0, q.inh[q.obj]} + 17'h00001;
    end

    // Dictionary access, answered one cycle later
    if (cfg_wr || cfg_rd) begin
      n.done = 1'b1;
      n.rdata = 32'h0;
      if (cfg_index == transmit_process_object_pkg::IDX_SYNC && cfg_sub == transmit_process_object_pkg::SUB_CNT) begin
        n.rdata = q.sync_id;
        if (cfg_wr) begin
          n.sync_id = cfg_wdata;
        end
      end else if (cfg_index[15:2] == transmit_process_object_pkg::IDX_COMM[15:2]) begin
        unique case (cfg_sub)
          transmit_process_object_pkg::SUB_CNT: begin
            n.rdata = transmit_process_object_pkg::COMM_LAST_SUB;
            n.err = cfg_wr;
          end
          transmit_process_object_pkg::SUB_COB: begin
            n.rdata = q.cob[c];
            if (cfg_wr) begin
              n.cob[c] = cfg_wdata;
            end
          end
          transmit_process_object_pkg::SUB_TYPE: begin
            n.rdata = {24'h0, q.ttype[c]};
            if (cfg_wr && cfg_wdata[7:0] > transmit_process_object_pkg::T_SYNC_MAX && cfg_wdata[7:0] < transmit_process_object_pkg::T_SYNC_RTR) begin
              n.err = 1'b1;
            end else if (cfg_wr) begin
              n.ttype[c] = cfg_wdata[7:0];
              n.scnt[c] = 8'h00;
            end
          end
          transmit_process_object_pkg::SUB_INH: begin
            n.rdata = {16'h0, q.inh[c]};
            if (cfg_wr) begin
              n.inh[c] = cfg_wdata[15:0];
            end
          end
          transmit_process_object_pkg::SUB_RSV: begin
            n.rdata = 32'h0;
          end
          transmit_process_object_pkg::SUB_EVT: begin
            n.rdata = {16'h0, q.evt[c]};
            if (cfg_wr) begin
              n.evt[c] = (cfg_wdata[15:0] != 16'h0000 && cfg_wdata[15:0] < transmit_process_object_pkg::EVT_MIN)
                ? transmit_process_object_pkg::EVT_MIN : cfg_wdata[15:0];
              n.evt_cnt[c] = 16'h0000;
            end
          end
          default: begin
            n.err = 1'b1;
          end
        endcase
      end else if (cfg_index[15:2] == transmit_process_object_pkg::IDX_MAP[15:2]) begin
        if (cfg_sub == transmit_process_object_pkg::SUB_CNT) begin
          n.rdata = {29'h0, q.mcnt[c]};
          if (cfg_wr) begin
            if (cfg_wdata > 32'd4 || map_bits(q.map[c], cfg_wdata[2:0]) > 11'd64) begin
              n.err = 1'b1;
            end else begin
              n.mcnt[c] = cfg_wdata[2:0];
            end
          end
        end else if (cfg_sub >= 8'h01 && cfg_sub <= 8'h04) begin
          n.rdata = q.map[c][cfg_sub[1:0] - 2'h1];
          if (cfg_wr && q.mcnt[c] != 3'h0) begin
            n.err = 1'b1;
          end else if (cfg_wr) begin
            n.map[c][cfg_sub[1:0] - 2'h1] = cfg_wdata;
          end
        end else begin
          n.err = 1'b1;
        end
      end else begin
        n.err = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= transmit_process_object_pkg::S_IDLE;
      q.sync_id <= transmit_process_object_pkg::SYNC_ID_RST;
      q.ttype <= {4{transmit_process_object_pkg::TYPE_RST}};
      q.evt <= {4{transmit_process_object_pkg::EVT_RST}};
      q.mcnt <= {4{transmit_process_object_pkg::MAPCNT_RST}};
    end else begin
      q <= n;
    end
  end
endmodule : canopen_transmit_process_object_sync_scheduler
`default_nettype wire

/* testbench/canopen_transmit_process_object_sync_scheduler_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module canopen_transmit_process_object_sync_scheduler_asserts (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset
  input wire logic cfg_wr, // Write strobe
  input wire logic cfg_rd, // Read strobe
  input wire logic cfg_done, // Access answered
  input wire logic cfg_err, // Access refused
  input wire logic [31:0] cfg_rdata, // Read value
  input wire logic tx_valid, // Frame offered
  input wire logic tx_ready, // Frame taken
  input wire logic [10:0] tx_id, // Frame identifier
  input wire logic [3:0] tx_dlc, // Frame length
  input wire logic [63:0] tx_data // Frame payload
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_CFG_ANSWER: assert property ((cfg_wr || cfg_rd) |=> cfg_done) else $error("access not answered");
  AST_DONE_CAUSE: assert property (cfg_done |-> $past(cfg_wr || cfg_rd)) else $error("answer without access");
  AST_ERR_WITH_DONE: assert property (cfg_err |-> cfg_done) else $error("refusal outside answer");
  AST_RDATA_HOLD: assert property (!(cfg_wr || cfg_rd) |=> $stable(cfg_rdata)) else $error("read value moved");
  AST_DLC_MAX: assert property (tx_valid |-> tx_dlc <= 4'h8) else $error("frame longer than eight bytes");
  AST_ID_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_id)) else $error("id dropped");
  AST_DATA_HOLD: assert property (tx_valid && !tx_ready |=> $stable(tx_data) && $stable(tx_dlc)) else $error("payload moved");
  AST_EMPTY_AFTER_RESET: assert property ($rose(rst_n) |-> !tx_valid) else $error("frame after reset");
endmodule : canopen_transmit_process_object_sync_scheduler_asserts
bind canopen_transmit_process_object_sync_scheduler canopen_transmit_process_object_sync_scheduler_asserts asserts_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_done(cfg_done), .cfg_err(cfg_err), .cfg_rdata(cfg_rdata),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data));
`default_nettype wire

/* testbench/can_master_model.sv */
`timescale 1ns/1ns
`default_nettype none
module can_master_model (
  input wire logic clk_sys, // System clock
  input wire logic hold, // Stall the controller
  input wire logic [15:0] dict_index, // Fetch address
  input wire logic [7:0] dict_sub, // Fetch sub-index
  output logic [31:0] dict_data, // Fetched value
  output logic rx_valid, // Frame strobe
  output logic [10:0] rx_id, // Frame identifier
  output logic rx_rtr, // Remote flag
  input wire logic tx_valid, // Frame offered
  output logic tx_ready, // Frame taken
  input wire logic [10:0] tx_id, // Offered identifier
  input wire logic [3:0] tx_dlc, // Offered length
  input wire logic [63:0] tx_data // Offered payload
);
  logic [31:0] bias = 32'h00000000;
  int got = 0;
  int cyc = 0;
  int last_t = 0;
  int gap_t = 0;
  logic [10:0] last_id;
  logic [3:0] last_dlc;
  logic [63:0] last_data;
  initial begin
    rx_valid = 1'b0;
    rx_id = 11'h7FF;
    rx_rtr = 1'b0;
  end
  // A non-zero sub-index corrupts the value, so a wrong fetch shows in the payload
  assign dict_data = {dict_index, dict_index ^ 16'h5A5A ^ {8'h00, dict_sub}} + bias;
  assign tx_ready = !hold;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (tx_valid && tx_ready) begin
      got <= got + 1;
      gap_t <= cyc - last_t;
      last_t <= cyc;
      last_id <= tx_id;
      last_dlc <= tx_dlc;
      last_data <= tx_data;
    end
  end
  // A SYNC is a bare identifier, no payload
  task send(input logic [10:0] id, input logic rtr);
    repeat (4) @(posedge clk_sys); // Bus time between frames
    @(posedge clk_sys);
    #1;
    rx_valid = 1'b1;
    rx_id = id;
    rx_rtr = rtr;
    @(posedge clk_sys);
    #1;
    rx_valid = 1'b0;
    rx_id = ~id;
    rx_rtr = !rtr;
  endtask : send
endmodule : can_master_model
`default_nettype wire

/* testbench/canopen_transmit_process_object_sync_scheduler_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module canopen_transmit_process_object_sync_scheduler_tb;
  localparam logic [6:0] NODE = 7'h05;
  localparam logic [10:0] SYNC = 11'h080;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic op = 1'b1;
  logic hold = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [15:0] cfg_index = 16'h0000;
  logic [7:0] cfg_sub = 8'h00;
  logic [31:0] cfg_wdata = 32'h00000000;
  logic cfg_done, cfg_err, rx_valid, rx_rtr, tx_valid, tx_ready;
  logic [31:0] cfg_rdata, dict_data;
  logic [15:0] dict_index;
  logic [7:0] dict_sub;
  logic [10:0] rx_id, tx_id;
  logic [3:0] tx_dlc;
  logic [63:0] tx_data;
  int failures = 0;
  int tests_run = 0;
  int c;
  initial begin
    forever #5 clk_sys = !clk_sys;
  end
  canopen_transmit_process_object_sync_scheduler #(.GAP_UNIT_CYCLES(10)) canopen_transmit_process_object_sync_scheduler_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .node_number(NODE), .operational(op), .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_index(cfg_index), .cfg_sub(cfg_sub), .cfg_wdata(cfg_wdata), .cfg_done(cfg_done),
    .cfg_err(cfg_err), .cfg_rdata(cfg_rdata), .dict_index(dict_index), .dict_sub(dict_sub), .dict_data(dict_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data));
  can_master_model partner_i (.clk_sys(clk_sys), .hold(hold), .dict_index(dict_index), .dict_sub(dict_sub),
    .dict_data(dict_data),
    .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
    .tx_dlc(tx_dlc), .tx_data(tx_data));
  task finish_test;
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  function automatic logic [63:0] pay(input logic [31:0] b);
    return {16'h0000, {16'h2018, 16'h2018 ^ 16'h5A5A} + b, 16'({16'h22A8, 16'h22A8 ^ 16'h5A5A} + b)};
  endfunction : pay
  task acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic ee,
           input logic [31:0] e);
    @(posedge clk_sys);
    #1;
    cfg_wr = w;
    cfg_rd = !w;
    cfg_index = i;
    cfg_sub = s;
    cfg_wdata = d;
    @(posedge clk_sys);
    #1;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    `CHK("cfg_done", 1'b1, cfg_done)
    `CHK("cfg_err", ee, cfg_err)
    if (!w && !ee) `CHK("cfg_rdata", e, cfg_rdata)
  endtask : acc
  task frames(input int n, input int bound, output int waited);
    int base;
    base = partner_i.got;
    waited = 0;
    while ((partner_i.got - base < n || n == 0) && waited < bound) begin
      @(posedge clk_sys);
      #1;
      waited++;
    end
    `CHK("frames", n, partner_i.got - base)
    if (n > 0 && waited >= bound) finish_test();
  endtask : frames
  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int k = 0; k < 4; k++) acc(0, 16'h1800 + 16'(k), 8'h01, 0, 0, {21'h0, 11'h180 + 11'h100 * 11'(k) + {4'h0, NODE}});
    acc(0, 16'h1015, 8'h00, 0, 0, 32'h00000080);
    acc(0, 16'h1800, 8'h00, 0, 0, 32'h00000005);
    acc(0, 16'h1800, 8'h02, 0, 0, 32'h000000FE);
    acc(0, 16'h1800, 8'h05, 0, 0, 32'h00000000);
    acc(0, 16'h1A00, 8'h00, 0, 0, 32'h00000000);
    acc(0, 16'h2000, 8'h00, 0, 1, 0);
    acc(1, 16'h1800, 8'h02, 32'h000000F5, 1, 0);
    acc(1, 16'h1A00, 8'h01, 32'h22A80010, 0, 0);
    acc(1, 16'h1A00, 8'h02, 32'h20180020, 0, 0);
    acc(1, 16'h1A00, 8'h00, 32'h00000002, 0, 0);
    acc(1, 16'h1A00, 8'h03, 32'h20180020, 1, 0);
    acc(1, 16'h1A00, 8'h00, 32'h00000005, 1, 0);
    acc(1, 16'h1800, 8'h02, 32'h00000000, 0, 0);
    partner_i.send(SYNC, 1'b0);
    frames(1, 40, c);
    `CHK("tx_id", 11'h185, partner_i.last_id)
    `CHK("tx_dlc", 4'h6, partner_i.last_dlc)
    `CHK("tx_data", pay(0), partner_i.last_data)
    frames(0, 100, c);
    acc(1, 16'h1800, 8'h02, 32'h00000003, 0, 0);
    c = partner_i.got;
    repeat (6) begin
      partner_i.send(SYNC, 1'b0);
      repeat (30) @(posedge clk_sys);
    end
    `CHK("every_third", 2, partner_i.got - c)
    acc(1, 16'h1800, 8'h02, 32'h000000FD, 0, 0);
    partner_i.send(11'h185, 1'b1);
    frames(1, 40, c);
    partner_i.send(11'h186, 1'b1);
    frames(0, 60, c);
    acc(1, 16'h1800, 8'h02, 32'h000000FC, 0, 0);
    partner_i.send(SYNC, 1'b0);
    frames(0, 60, c);
    partner_i.send(11'h185, 1'b1);
    frames(1, 40, c);
    acc(1, 16'h1800, 8'h02, 32'h00000001, 0, 0);
    op = 1'b0;
    partner_i.send(SYNC, 1'b0);
    frames(0, 60, c);
    op = 1'b1;
    acc(1, 16'h1800, 8'h01, 32'h80000185, 0, 0);
    partner_i.send(SYNC, 1'b0);
    frames(0, 60, c);
    acc(1, 16'h1800, 8'h01, 32'h00000185, 0, 0);
    acc(1, 16'h1800, 8'h03, 32'h0000001E, 0, 0);
    partner_i.send(SYNC, 1'b0);
    frames(1, 40, c);
    repeat (40) @(posedge clk_sys);
    partner_i.send(SYNC, 1'b0);
    frames(1, 400, c);
    `CHK("gap", 1'b1, partner_i.gap_t >= 300 && partner_i.gap_t <= 330)
    acc(1, 16'h1800, 8'h03, 32'h00000000, 0, 0);
    frames(0, 320, c);
    acc(1, 16'h1800, 8'h02, 32'h000000FE, 0, 0);
    acc(1, 16'h1800, 8'h05, 32'h00000001, 0, 0);
    acc(0, 16'h1800, 8'h05, 0, 0, 32'h00000002);
    frames(2, 500, c);
    `CHK("period", 1'b1, partner_i.gap_t >= 196 && partner_i.gap_t <= 204)
    acc(1, 16'h1800, 8'h05, 32'h00000000, 0, 0);
    frames(0, 300, c);
    acc(1, 16'h1800, 8'h02, 32'h000000FF, 0, 0);
    frames(0, 100, c);
    partner_i.bias = partner_i.bias + 32'h00000001;
    frames(1, 60, c);
    acc(1, 16'h1800, 8'h02, 32'h00000001, 0, 0);
    hold = 1'b1;
    c = partner_i.got;
    partner_i.send(SYNC, 1'b0);
    repeat (30) @(posedge clk_sys);
    #1;
    `CHK("tx_valid", 1'b1, tx_valid)
    `CHK("held", c, partner_i.got)
    hold = 1'b0;
    frames(1, 20, c);
    `CHK("tx_data", pay(1), partner_i.last_data)
    finish_test();
  end
endmodule : canopen_transmit_process_object_sync_scheduler_tb
`default_nettype wire
